// *** common/fbp_defines.svh ***
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH

// Station status octet fields
`define FBP_WD_ON_BIT      3
`define FBP_FREEZE_BIT     4
`define FBP_SYNC_BIT       5
`define FBP_UNLOCK_BIT     6
`define FBP_LOCK_BIT       7

// Parameter telegram octet positions, counted from zero
`define FBP_POS_STATUS     8'h00
`define FBP_POS_WDF1       8'h01
`define FBP_POS_WDF2       8'h02
`define FBP_POS_TSDR       8'h03
`define FBP_POS_ID_HI      8'h04
`define FBP_POS_ID_LO      8'h05
`define FBP_POS_GROUP      8'h06
`define FBP_POS_USER       8'h07
`define FBP_POS_LAST       8'hC5
`define FBP_USER_BYTES     4

// Identifier bytes
`define FBP_ID_NODE        8'h40
`define FBP_ID_NODE2       8'h00
`define FBP_ID_IN1         8'h10
`define FBP_ID_OUT1        8'h20
`define FBP_ID_INOUT1      8'h30
`define FBP_ID_UPPER4      8'h00
`define FBP_CFG_DEPTH      32

// Own identification number, value arbitrary
`define FBP_OWN_IDENT      16'h1A2B

// Timing
`define FBP_CLK_KHZ        25000
`define FBP_WD_UNIT_MS     10
`define FBP_WD_TICK_CYC    (`FBP_WD_UNIT_MS * `FBP_CLK_KHZ)
`define FBP_BIT_CYC        1

// Register offsets of the master controller
`define FBP_REG_CTRL       12'h000
`define FBP_REG_STATUS     12'h004
`define FBP_REG_PRM        12'h008
`define FBP_REG_IDENT      12'h00C
`define FBP_REG_CFG        12'h010
`define FBP_REG_CFG_LEN    12'h014
`define FBP_REG_OUT        12'h018
`define FBP_REG_USER       12'h01C
`define FBP_CTRL_START     0
`define FBP_CTRL_RUN       1
`define FBP_PRM_RESET      32'h0000_0108

`endif

// *** common/fbp_pkg.sv ***
package fbp_pkg;
    typedef enum logic [1:0] {
        FBP_TG_DIAG,
        FBP_TG_PRM,
        FBP_TG_CFG,
        FBP_TG_DATA
    } fbp_kind_t;

    typedef enum logic [1:0] {
        FBP_LOCK_FREE,
        FBP_LOCK_RELEASED,
        FBP_LOCK_BLOCKED
    } fbp_lock_t;

    typedef enum {
        FBP_M_IDLE,
        FBP_M_SEND,
        FBP_M_WAIT
    } fbp_mstate_t;
endpackage

// *** common/fbp_link_if.sv ***
`timescale 1ns/1ps
interface fbp_link_if;
    logic                  m_valid;
    logic                  m_last;
    fbp_pkg::fbp_kind_t    m_kind;
    logic [7:0]            m_data;
    logic                  s_resp;
    logic                  s_ok;
    logic [7:0]            s_data;

    modport master (output m_valid, output m_last, output m_kind, output m_data,
                    input s_resp, input s_ok, input s_data);
    modport slave  (input m_valid, input m_last, input m_kind, input m_data,
                    output s_resp, output s_ok, output s_data);
endinterface

// *** hw/fbp_slave.sv ***
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "fbp_defines.svh"
// Summary of operation
// - Master: diag, parameters, config, data, diag
// - Split parameters, forward each to module
// - Master resends parameters after every interruption; this master stops in idle with its error bit set until started again
// - Status bit 3 enables response watchdog
// - Status bit 4 requests freeze mode
// - Status bit 5 requests sync mode
// - Bits 7,6 decode lock and release
// - Watchdog time is 10 ms times factors
// - Wait minimum station delay before replying
// - Accept parameters only on matching ident
// - Group ident octet ignored
// - Octets 8 to 198 forwarded as user parameters
// - Master sends configuration after parameters
// - Node status entry is 40h, 00h
// - 10h input, 20h output, 30h both
// - 00h uses upper half of output byte
// - Pneumatic identifier matches fitted valves
module fbp_slave #(
    parameter int unsigned WD_TICK_CYC = `FBP_WD_TICK_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    fbp_link_if.slave        link,
    input  wire logic        exp_wr_i,
    input  wire logic [4:0]  exp_idx_i,
    input  wire logic [7:0]  exp_data_i,
    input  wire logic [5:0]  exp_len_i,
    input  wire logic [7:0]  in_byte_i,
    output logic             wd_en_o,
    output logic             freeze_o,
    output logic             sync_o,
    output fbp_pkg::fbp_lock_t lock_o,
    output logic [7:0]       min_tsdr_o,
    output logic             prm_wr_o,
    output logic [7:0]       prm_idx_o,
    output logic [7:0]       prm_data_o,
    output logic             data_ex_o,
    output logic             out_valid_o,
    output logic [7:0]       out_byte_o,
    output logic [5:0]       in_len_o,
    output logic [5:0]       out_len_o,
    output logic             wd_expired_o
);
    logic [7:0]  exp_mem [`FBP_CFG_DEPTH];
    logic [7:0]  pos_r, st_r, f1_r, f2_r, tsdr_r, wf1_r, wf2_r, rdat_r;
    logic [15:0] id_r, dly_r, wd_cnt_r;
    logic        bad_r, prm_done_r, cfg_done_r, half_r, pend_r, ok_r;
    logic [5:0]  in_cnt_r, out_cnt_r;
    logic [31:0] tick_r;
    logic        wd_exp, tg_end, prm_acc, cfg_acc;
    function automatic logic [1:0] lock_dec(input logic [7:0] st);
        lock_dec = {st[`FBP_LOCK_BIT], st[`FBP_UNLOCK_BIT]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Expected module identifiers, one per fitted module
    always_ff @(posedge sys_clk_i) begin
        if (exp_wr_i) begin
            exp_mem[exp_idx_i] <= exp_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Telegram byte position
    assign tg_end = link.m_valid && link.m_last;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || tg_end) begin
            pos_r <= 8'h00;
        end else if (link.m_valid && pos_r != 8'hFF) begin
            pos_r <= pos_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter telegram capture
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_r  <= 8'h00;
            wf1_r <= 8'h00;
            wf2_r <= 8'h00;
            tsdr_r <= 8'h00;
            id_r  <= 16'h0000;
        end else if (link.m_valid && link.m_kind == fbp_pkg::FBP_TG_PRM) begin
            case (pos_r)
                `FBP_POS_STATUS: st_r <= link.m_data;
                `FBP_POS_WDF1:   wf1_r <= link.m_data;
                `FBP_POS_WDF2:   wf2_r <= link.m_data;
                `FBP_POS_TSDR:   tsdr_r <= link.m_data;
                `FBP_POS_ID_HI:  id_r[15:8] <= link.m_data;
                `FBP_POS_ID_LO:  id_r[7:0] <= link.m_data;
                default:         id_r <= id_r;
            endcase
        end
    end

    // Ident arrives before user data, so forwarding is gated by it
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            prm_wr_o   <= 1'b0;
            prm_idx_o  <= 8'h00;
            prm_data_o <= 8'h00;
        end else begin
            prm_wr_o   <= link.m_valid && link.m_kind == fbp_pkg::FBP_TG_PRM
                          && pos_r >= `FBP_POS_USER && pos_r <= `FBP_POS_LAST
                          && id_r == `FBP_OWN_IDENT;
            prm_idx_o  <= pos_r - `FBP_POS_USER;
            prm_data_o <= link.m_data;
        end
    end
    assign prm_acc = tg_end && link.m_kind == fbp_pkg::FBP_TG_PRM && pos_r >= `FBP_POS_GROUP
                     && id_r == `FBP_OWN_IDENT && wf1_r != 8'h00 && wf2_r != 8'h00;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wd_en_o    <= 1'b0;
            freeze_o   <= 1'b0;
            sync_o     <= 1'b0;
            lock_o     <= fbp_pkg::FBP_LOCK_FREE;
            min_tsdr_o <= 8'h00;
            f1_r       <= 8'h01;
            f2_r       <= 8'h01;
        end else if (prm_acc) begin
            wd_en_o  <= st_r[`FBP_WD_ON_BIT];
            freeze_o <= st_r[`FBP_FREEZE_BIT];
            sync_o   <= st_r[`FBP_SYNC_BIT];
            f1_r     <= wf1_r;
            f2_r     <= wf2_r;
            case (lock_dec(st_r))
                2'h0: begin
                    lock_o     <= fbp_pkg::FBP_LOCK_FREE;
                    min_tsdr_o <= tsdr_r;
                end
                2'h2: lock_o <= fbp_pkg::FBP_LOCK_BLOCKED;
                default: lock_o <= fbp_pkg::FBP_LOCK_RELEASED;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Configuration check and address space count
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || tg_end) begin
            bad_r     <= 1'b0;
            in_cnt_r  <= 6'h00;
            out_cnt_r <= 6'h00;
            half_r    <= 1'b0;
        end else if (link.m_valid && link.m_kind == fbp_pkg::FBP_TG_CFG) begin
            if (pos_r >= 8'(`FBP_CFG_DEPTH) || link.m_data != exp_mem[pos_r[4:0]]
                || (pos_r == 8'h00 && link.m_data != `FBP_ID_NODE)
                || (pos_r == 8'h01 && link.m_data != `FBP_ID_NODE2)) begin
                bad_r <= 1'b1;
            end
            if (pos_r >= 8'h02) begin
                case (link.m_data)
                    `FBP_ID_IN1:    in_cnt_r <= in_cnt_r + 6'h01;
                    `FBP_ID_OUT1: begin
                        out_cnt_r <= out_cnt_r + 6'h01;
                        half_r    <= 1'b1;
                    end
                    `FBP_ID_INOUT1: begin
                        in_cnt_r  <= in_cnt_r + 6'h01;
                        out_cnt_r <= out_cnt_r + 6'h01;
                    end
                    `FBP_ID_UPPER4: begin
                        if (!half_r) begin
                            bad_r <= 1'b1;
                        end
                        half_r <= 1'b0;
                    end
                    default: out_cnt_r <= out_cnt_r + 6'h01;
                endcase
            end
        end
    end
    assign cfg_acc = tg_end && link.m_kind == fbp_pkg::FBP_TG_CFG && prm_done_r && !bad_r
                     && pos_r + 8'h01 == {2'b00, exp_len_i} && pos_r < 8'(`FBP_CFG_DEPTH)
                     && link.m_data == exp_mem[pos_r[4:0]] && pos_r >= 8'h01
                     && (pos_r != 8'h01 || link.m_data == `FBP_ID_NODE2)
                     && (pos_r < 8'h02 || link.m_data != `FBP_ID_UPPER4 || half_r);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            in_len_o  <= 6'h00;
            out_len_o <= 6'h00;
        end else if (cfg_acc) begin
            in_len_o  <= in_cnt_r + ((link.m_data == `FBP_ID_IN1 || link.m_data == `FBP_ID_INOUT1) ? 6'h01 : 6'h00);
            out_len_o <= out_cnt_r + ((link.m_data == `FBP_ID_UPPER4 || link.m_data == `FBP_ID_IN1) ? 6'h00 : 6'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Startup state and data exchange
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || wd_exp) begin
            prm_done_r <= 1'b0;
            cfg_done_r <= 1'b0;
        end else if (prm_acc) begin
            prm_done_r <= 1'b1;
            cfg_done_r <= 1'b0;
        end else if (tg_end && link.m_kind == fbp_pkg::FBP_TG_CFG) begin
            cfg_done_r <= cfg_acc;
        end
    end
    assign data_ex_o = prm_done_r && cfg_done_r;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            out_valid_o <= 1'b0;
            out_byte_o  <= 8'h00;
        end else begin
            out_valid_o <= link.m_valid && link.m_kind == fbp_pkg::FBP_TG_DATA && data_ex_o;
            if (link.m_valid && link.m_kind == fbp_pkg::FBP_TG_DATA && data_ex_o) begin
                out_byte_o <= link.m_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response watchdog
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || tg_end || !(data_ex_o && wd_en_o)) begin
            tick_r   <= 32'h0;
            wd_cnt_r <= 16'h0;
        end else if (tick_r == 32'(WD_TICK_CYC - 1)) begin
            tick_r   <= 32'h0;
            wd_cnt_r <= wd_cnt_r + 16'h1;
        end else begin
            tick_r <= tick_r + 32'h1;
        end
    end
    assign wd_exp = data_ex_o && wd_en_o && !tg_end && wd_cnt_r == f1_r * f2_r;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wd_expired_o <= 1'b0;
        end else begin
            wd_expired_o <= wd_exp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply after minimum station delay
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pend_r <= 1'b0;
            ok_r   <= 1'b0;
            rdat_r <= 8'h00;
            dly_r  <= 16'h0;
        end else if (tg_end) begin
            pend_r <= 1'b1;
            dly_r  <= 16'(min_tsdr_o * `FBP_BIT_CYC);
            case (link.m_kind)
                fbp_pkg::FBP_TG_PRM: ok_r <= prm_acc;
                fbp_pkg::FBP_TG_CFG: ok_r <= cfg_acc;
                fbp_pkg::FBP_TG_DATA: ok_r <= data_ex_o;
                default: ok_r <= 1'b1;
            endcase
            rdat_r <= (link.m_kind == fbp_pkg::FBP_TG_DIAG)
                      ? {6'h00, cfg_done_r, prm_done_r} : in_byte_i;
        end else if (pend_r && dly_r != 16'h0) begin
            dly_r <= dly_r - 16'h1;
        end else begin
            pend_r <= 1'b0;
        end
    end

    assign link.s_resp = pend_r && dly_r == 16'h0;
    assign link.s_ok   = ok_r;
    assign link.s_data = rdat_r;
endmodule

// *** hw/fbp_master.sv ***
`timescale 1ns/1ps
`include "fbp_defines.svh"
module fbp_master (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    fbp_link_if.master       link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    logic [7:0]          cfg_mem [`FBP_CFG_DEPTH];
    logic [31:0]         prm_r, user_r;
    logic [15:0]         ident_r;
    logic [5:0]          cfg_len_r;
    logic [7:0]          out_r, in_r;
    logic                run_r, fin_r;
    logic [2:0]          ok_r;
    logic                err_r;
    fbp_pkg::fbp_mstate_t st_r;
    fbp_pkg::fbp_kind_t   kind_r;
    logic [7:0]          idx_r, len;
    logic                wr, rd, start;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign start   = wr && paddr == `FBP_REG_CTRL && pwdata[`FBP_CTRL_START];
    assign pready  = 1'b1;

    function automatic logic mapped(input logic [11:0] a);
        mapped = a <= `FBP_REG_USER && a[1:0] == 2'b00;
    endfunction

    assign pslverr = psel && penable && !mapped(paddr);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            prm_r     <= `FBP_PRM_RESET;
            user_r    <= 32'h0;
            ident_r   <= `FBP_OWN_IDENT;
            cfg_len_r <= 6'h00;
            out_r     <= 8'h00;
            run_r     <= 1'b0;
        end else if (wr) begin
            case (paddr)
                `FBP_REG_CTRL:    run_r <= pwdata[`FBP_CTRL_RUN];
                `FBP_REG_PRM:     prm_r <= pwdata;
                `FBP_REG_IDENT:   ident_r <= pwdata[15:0];
                `FBP_REG_CFG_LEN: cfg_len_r <= pwdata[5:0];
                `FBP_REG_OUT:     out_r <= pwdata[7:0];
                `FBP_REG_USER:    user_r <= pwdata;
                default:          out_r <= out_r;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (wr && paddr == `FBP_REG_CFG) begin
            cfg_mem[pwdata[12:8]] <= pwdata[7:0];
        end
    end

    always_comb begin
        prdata = 32'h0;
        if (rd) begin
            case (paddr)
                `FBP_REG_CTRL:    prdata = {30'h0, run_r, 1'b0};
                `FBP_REG_STATUS:  prdata = {16'h0, in_r, 1'b0, err_r, ok_r, 1'b0, 2'(st_r)};
                `FBP_REG_PRM:     prdata = prm_r;
                `FBP_REG_IDENT:   prdata = {16'h0, ident_r};
                `FBP_REG_CFG_LEN: prdata = {26'h0, cfg_len_r};
                `FBP_REG_OUT:     prdata = {24'h0, out_r};
                `FBP_REG_USER:    prdata = user_r;
                default:          prdata = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Telegram bytes
    always_comb begin
        case (kind_r)
            fbp_pkg::FBP_TG_PRM:  len = 8'(`FBP_POS_USER + `FBP_USER_BYTES);
            fbp_pkg::FBP_TG_CFG:  len = {2'b00, cfg_len_r};
            default:              len = 8'h01;
        endcase
    end

    always_comb begin
        case (kind_r)
            fbp_pkg::FBP_TG_PRM: begin
                case (idx_r)
                    `FBP_POS_STATUS: link.m_data = prm_r[7:0];
                    `FBP_POS_WDF1:   link.m_data = prm_r[15:8];
                    `FBP_POS_WDF2:   link.m_data = prm_r[23:16];
                    `FBP_POS_TSDR:   link.m_data = prm_r[31:24];
                    `FBP_POS_ID_HI:  link.m_data = ident_r[15:8];
                    `FBP_POS_ID_LO:  link.m_data = ident_r[7:0];
                    `FBP_POS_GROUP:  link.m_data = 8'h00;
                    default:         link.m_data = user_r[8*(2'(idx_r - `FBP_POS_USER)) +: 8];
                endcase
            end
            fbp_pkg::FBP_TG_CFG:  link.m_data = cfg_mem[idx_r[4:0]];
            fbp_pkg::FBP_TG_DATA: link.m_data = out_r;
            default:              link.m_data = 8'h00;
        endcase
    end

    assign link.m_valid = st_r == fbp_pkg::FBP_M_SEND;
    assign link.m_last  = link.m_valid && idx_r + 8'h01 >= len;
    assign link.m_kind  = kind_r;

    ////////////////////////////////////////////////////////////////////////
    // Startup sequence
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_r   <= fbp_pkg::FBP_M_IDLE;
            kind_r <= fbp_pkg::FBP_TG_DIAG;
            idx_r  <= 8'h00;
            ok_r   <= 3'h0;
            err_r  <= 1'b0;
            fin_r  <= 1'b0;
            in_r   <= 8'h00;
        end else begin
            case (st_r)
                fbp_pkg::FBP_M_IDLE: begin
                    if (start) begin
                        st_r   <= fbp_pkg::FBP_M_SEND;
                        kind_r <= fbp_pkg::FBP_TG_DIAG;
                        ok_r   <= 3'h0;
                        err_r  <= 1'b0;
                        fin_r  <= 1'b0;
                        idx_r  <= 8'h00;
                    end
                end
                fbp_pkg::FBP_M_SEND: begin
                    idx_r <= idx_r + 8'h01;
                    if (link.m_last) begin
                        st_r <= fbp_pkg::FBP_M_WAIT;
                    end
                end
                fbp_pkg::FBP_M_WAIT: begin
                    if (link.s_resp) begin
                        idx_r <= 8'h00;
                        st_r  <= fbp_pkg::FBP_M_SEND;
                        if (!link.s_ok) begin
                            err_r <= 1'b1;
                            st_r  <= fbp_pkg::FBP_M_IDLE;
                        end else begin
                            case (kind_r)
                                fbp_pkg::FBP_TG_DIAG: begin
                                    kind_r <= fbp_pkg::FBP_TG_PRM;
                                    if (fin_r) begin
                                        st_r <= fbp_pkg::FBP_M_IDLE;
                                    end
                                end
                                fbp_pkg::FBP_TG_PRM: begin
                                    ok_r[0] <= 1'b1;
                                    kind_r  <= fbp_pkg::FBP_TG_CFG;
                                end
                                fbp_pkg::FBP_TG_CFG: begin
                                    ok_r[1] <= 1'b1;
                                    kind_r  <= fbp_pkg::FBP_TG_DATA;
                                end
                                default: begin
                                    ok_r[2] <= 1'b1;
                                    in_r    <= link.s_data;
                                    if (!run_r) begin
                                        kind_r <= fbp_pkg::FBP_TG_DIAG;
                                        fin_r  <= 1'b1;
                                    end
                                end
                            endcase
                        end
                    end
                end
                default: st_r <= fbp_pkg::FBP_M_IDLE;
            endcase
        end
    end
endmodule

// *** verif/fbp_link_props.sv ***
`timescale 1ns/1ps
module fbp_link_props (
    input  wire logic               sys_clk_i,
    input  wire logic               reset_i,
    input  wire logic               m_valid,
    input  wire logic               m_last,
    input  wire fbp_pkg::fbp_kind_t m_kind,
    input  wire logic [7:0]         m_data,
    input  wire logic               s_resp,
    input  wire logic               s_ok,
    input  wire logic [7:0]         s_data
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////
    sequence tg_end; m_valid && m_last; endsequence
    sequence reply_due; ##[1:256] s_resp; endsequence
    a_reply_bound: assert property (tg_end |-> reply_due) else $error("no reply");
    a_reply_pulse: assert property (s_resp |=> !s_resp) else $error("long reply");
    a_wait_reply: assert property (tg_end |=> !m_valid until s_resp) else $error("early send");
    a_no_overlap: assert property (m_valid |-> !s_resp) else $error("reply in telegram");
    a_last_valid: assert property (m_last |-> m_valid) else $error("stray last");
    a_kind_held: assert property (m_valid && !m_last |=> m_valid && $stable(m_kind)) else $error("kind moved");
    a_reply_held: assert property (s_resp |=> $stable(s_ok) && $stable(s_data)) else $error("reply moved");
    a_idle_reset: assert property ($fell(reset_i) |-> !m_valid && !s_resp) else $error("busy link");
    a_cfg_head: assert property ($rose(m_valid) && m_kind == fbp_pkg::FBP_TG_CFG |->
        m_data == 8'h40 ##1 m_data == 8'h00) else $error("bad node entry");
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        sys_clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic        exp_wr_i = 1'b0, wd_en_o, freeze_o, sync_o, prm_wr_o, data_ex_o, out_valid_o, wd_expired_o;
    logic [4:0]  exp_idx_i = 5'h00;
    logic [7:0]  exp_data_i = 8'h00, in_byte_i = 8'h00, min_tsdr_o, prm_idx_o, prm_data_o, out_byte_o, tsdr = 8'h00;
    logic [5:0]  exp_len_i = 6'h00, in_len_o, out_len_o;
    fbp_pkg::fbp_lock_t lock_o;
    logic [7:0]  ub [4];
    logic [7:0]  cfg [6] = '{8'h40, 8'h00, 8'h10, 8'h20, 8'h30, 8'h00};
    // Expected {wd, freeze, sync, lock} beside station status
    logic [15:0] rows [7] = '{16'h1008, 16'h0810, 16'h0420, 16'h0140, 16'h0280, 16'h01C0, 16'h1C38};
    logic        wd_seen = 1'b0, re;
    int          error_cnt = 0, checks_done = 0, gap = 0, last_gap = 0, i, n;
    fbp_link_if fbp_link_if_i ();
    fbp_master fbp_master_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(fbp_link_if_i.master), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    fbp_slave #(.WD_TICK_CYC(10)) fbp_slave_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(fbp_link_if_i.slave),
        .exp_wr_i(exp_wr_i), .exp_idx_i(exp_idx_i), .exp_data_i(exp_data_i), .exp_len_i(exp_len_i),
        .in_byte_i(in_byte_i), .wd_en_o(wd_en_o), .freeze_o(freeze_o), .sync_o(sync_o), .lock_o(lock_o),
        .min_tsdr_o(min_tsdr_o), .prm_wr_o(prm_wr_o), .prm_idx_o(prm_idx_o), .prm_data_o(prm_data_o),
        .data_ex_o(data_ex_o), .out_valid_o(out_valid_o), .out_byte_o(out_byte_o), .in_len_o(in_len_o),
        .out_len_o(out_len_o), .wd_expired_o(wd_expired_o));
    fbp_link_props fbp_link_props_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .m_valid(fbp_link_if_i.m_valid),
        .m_last(fbp_link_if_i.m_last), .m_kind(fbp_link_if_i.m_kind), .m_data(fbp_link_if_i.m_data),
        .s_resp(fbp_link_if_i.s_resp), .s_ok(fbp_link_if_i.s_ok), .s_data(fbp_link_if_i.s_data));
    always #20 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (prm_wr_o === 1'b1) ub[prm_idx_o[1:0]] <= prm_data_o;
        if (wd_expired_o === 1'b1) wd_seen <= 1'b1;
        gap <= (fbp_link_if_i.m_valid && fbp_link_if_i.m_last) ? 0 : gap + 1;
        if (fbp_link_if_i.s_resp === 1'b1) last_gap <= gap + 1;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic hang(input string m);
        chk(32'h1, 32'h0, m);
        print_verdict();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge sys_clk_i);
            if (pready === 1'b1) break;
        end
        rv = prdata;
        re = pslverr;
        if (k == 50) hang("apb");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic run(input logic [31:0] c);
        int k;
        apb(1'b1, 12'h000, c);
        for (k = 0; k < 300; k++) begin
            apb(1'b0, 12'h004, 32'h0);
            if (rv[1:0] === 2'b00) break;
        end
        if (k == 300) hang("sequence");
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        chk({data_ex_o, wd_en_o}, 0, "reset outputs");
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, 32'h0000_0108, "prm reset");
        apb(1'b0, 12'h020, 32'h0);
        chk(rv, 0, "unmapped read");
        chk(re, 1, "unmapped");
        for (i = 0; i < 6; i++) begin
            exp_wr_i <= 1'b1;
            exp_idx_i <= 5'(i);
            exp_data_i <= cfg[i];
            apb(1'b1, 12'h010, {19'h0, 5'(i), cfg[i]});
        end
        exp_wr_i <= 1'b0;
        exp_len_i <= 6'd6;
        apb(1'b1, 12'h014, 32'd6);
        apb(1'b1, 12'h01C, 32'h4433_2211);
        for (i = 0; i < 7; i++) begin
            apb(1'b1, 12'h008, {8'(i + 2), 16'h0505, rows[i][7:0]});
            if (rows[i][7:6] == 2'b00) tsdr = 8'(i + 2);
            run(1);
            chk({wd_en_o, freeze_o, sync_o, lock_o}, rows[i][12:8], "mode");
            chk({min_tsdr_o, data_ex_o}, {tsdr, 1'b1}, "delay or exchange");
            chk(last_gap, tsdr + 1, "reply gap");
        end
        chk({ub[3], ub[2], ub[1], ub[0]}, 32'h4433_2211, "user bytes");
        chk({in_len_o, out_len_o}, {6'd2, 6'd2}, "image size");
        in_byte_i <= 8'hC3;
        apb(1'b1, 12'h018, 32'h5A);
        apb(1'b1, 12'h000, 32'h3);
        for (n = 0; n < 300 && out_valid_o !== 1'b1; n++) @(posedge sys_clk_i);
        chk(out_byte_o, 8'h5A, "output byte");
        run(0);
        chk(rv[15:8], 8'hC3, "input byte");
        for (n = 0; n < 400 && wd_seen !== 1'b1; n++) @(posedge sys_clk_i);
        chk({wd_seen, data_ex_o}, 2'b10, "watchdog");
        apb(1'b1, 12'h00C, 32'h1A2C);
        apb(1'b1, 12'h008, 32'h0A05_0500);
        run(1);
        chk({rv[6], wd_en_o}, 2'b11, "ident refused");
        apb(1'b1, 12'h00C, 32'h1A2B);
        apb(1'b1, 12'h014, 32'd5);
        run(1);
        chk({rv[6], wd_en_o, data_ex_o}, 3'b100, "config refused");
        print_verdict();
    end
endmodule
